// *** core/fpm_host.sv ***
// Purpose: host controller driving the flash write-guard and mode pins
// Assumes: APB slave for software, one clock, zero wait state answers
// Notes: flash pin inputs pass three flops before use
//
// Implementation choices: the register offsets and the APB register port.
module fpm_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output fpm_pkg::fpm_pins_s pins,
    input wire logic [15:0] dq_i,
    input wire logic ry_by_n_i
);
    import fpm_pkg::*;

    typedef struct packed {
        fpm_state_e st;
        fpm_mode_e mode;
        fpm_pins_s pins;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [3:0] req_op;
        logic go;
        logic wp;
        logic top;
        logic uni;
        logic slock;
        logic [21:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [3:0] cur_op;
        logic [21:0] cur_addr;
        logic [15:0] cur_data;
        logic [2:0] step;
        logic [7:0] cnt;
        logic refused;
        logic redo;
        logic lost;
        logic redo_pend;
        logic [15:0] dq_s1, dq_s2, dq_s3;
        logic [2:0] rb_s;
    } fpm_state_s;

    fpm_state_s q, d;

    function automatic logic is_pe(input logic [3:0] op);
        return op == OP_PROG || op == OP_SERASE || op == OP_CERASE ||
               op == OP_BPROG || op == OP_BSERASE;
    endfunction : is_pe

    function automatic logic in_boot(input logic [21:0] a,
                                     input logic top, input logic uni);
        if (uni)
            return top ? (a >= BOOT_UNI_TOP_BEG) : (a <= BOOT_UNI_BOT_END);
        else
            return top ? (a >= BOOT_NU_TOP_BEG) : (a <= BOOT_NU_BOT_END);
    endfunction : in_boot

    function automatic fpm_seq_s seq_f(input logic [3:0] op,
                                       input logic [2:0] st,
                                       input logic [21:0] a,
                                       input logic [15:0] dat);
        fpm_seq_s s;
        s.addr = a;
        s.data = dat;
        s.last = 1'b0;
        case (op)
            OP_PROG, OP_IDENT, OP_SECENT, OP_BENTER: begin
                if (st == 3'd0) begin
                    s.addr = A_555;
                    s.data = D_AA;
                end else if (st == 3'd1) begin
                    s.addr = A_2AA;
                    s.data = D_55;
                end else if (st == 3'd2) begin
                    s.addr = A_555;
                    s.data = (op == OP_PROG) ? D_PROG :
                             (op == OP_IDENT) ? D_IDENT :
                             (op == OP_SECENT) ? D_SECENT : D_BENTER;
                    s.last = (op != OP_PROG);
                end else begin
                    s.last = 1'b1;
                end
            end
            OP_SERASE, OP_CERASE: begin
                if (st == 3'd0 || st == 3'd3) begin
                    s.addr = A_555;
                    s.data = D_AA;
                end else if (st == 3'd1 || st == 3'd4) begin
                    s.addr = A_2AA;
                    s.data = D_55;
                end else if (st == 3'd2) begin
                    s.addr = A_555;
                    s.data = D_ERASE;
                end else begin
                    s.addr = (op == OP_CERASE) ? A_555 : a;
                    s.data = (op == OP_CERASE) ? D_CHIP : D_SECT;
                    s.last = 1'b1;
                end
            end
            OP_BPROG, OP_BSERASE, OP_BEXIT: begin
                if (st == 3'd0) begin
                    s.data = (op == OP_BPROG) ? D_PROG :
                             (op == OP_BSERASE) ? D_ERASE : D_BEXIT1;
                end else begin
                    s.data = (op == OP_BPROG) ? dat :
                             (op == OP_BSERASE) ? D_SECT : D_BEXIT2;
                    s.last = 1'b1;
                end
            end
            OP_QENTER: begin
                s.addr = A_55;
                s.data = D_QUERY;
                s.last = 1'b1;
            end
            OP_EXIT: begin
                s.data = D_EXIT;
                s.last = 1'b1;
            end
            default: begin
                s.last = 1'b1;
            end
        endcase
        return s;
    endfunction : seq_f

    function automatic logic refuse_f(input logic [3:0] op,
                                      input fpm_mode_e md,
                                      input logic [21:0] a,
                                      input logic wp, input logic top,
                                      input logic uni, input logic slock);
        logic byp_op;
        logic r;
        byp_op = op == OP_BPROG || op == OP_BSERASE || op == OP_BEXIT;
        r = 1'b0;
        if (is_pe(op) && !wp && (op == OP_CERASE || in_boot(a, top, uni)))
            r = 1'b1;
        if (md == MD_BYP && !byp_op && op != OP_READ && op != OP_RESET)
            r = 1'b1;
        if (md != MD_BYP && byp_op)
            r = 1'b1;
        if (md == MD_SEC && (op == OP_SERASE || op == OP_CERASE ||
                             op == OP_BSERASE))
            r = 1'b1;
        if (md == MD_SEC && (op == OP_PROG || op == OP_BPROG) &&
            (slock || a <= SEC_UID_END))
            r = 1'b1;
        return r;
    endfunction : refuse_f

    fpm_seq_s sq;
    logic acc;
    logic stable_rb;

    always_comb begin
        d = q;
        sq = seq_f(q.cur_op, q.step, q.cur_addr, q.cur_data);
        acc = psel && penable && q.pready;
        stable_rb = q.rb_s[1] == q.rb_s[2];
        d.dq_s1 = dq_i;
        d.dq_s2 = q.dq_s1;
        d.dq_s3 = q.dq_s2;
        d.rb_s = {q.rb_s[1:0], ry_by_n_i};
        d.pins.wp_n = q.wp;
        d.pready = psel && !penable;
        d.pslverr = 1'b0;
        d.prdata = 32'h0000_0000;
        // setup phase decode, answered in the first access cycle
        if (psel && !penable) begin
            if (paddr == REG_CTRL) begin
                d.prdata = {20'h00000, q.slock, q.uni, q.top, q.wp,
                            4'h0, q.req_op};
            end else if (paddr == REG_ADDR) begin
                d.prdata = {10'h000, q.addr};
            end else if (paddr == REG_WDATA) begin
                d.prdata = {16'h0000, q.wdata};
            end else if (paddr == REG_RDATA) begin
                d.prdata = {16'h0000, q.rdata};
            end else if (paddr == REG_STATUS) begin
                d.prdata = {25'h0000000, q.lost, q.redo, q.refused,
                            q.st != ST_IDLE || q.go, q.mode};
            end else begin
                d.pslverr = 1'b1;
            end
        end
        if (acc && pwrite) begin
            if (paddr == REG_CTRL) begin
                d.req_op = pwdata[3:0];
                d.go = 1'b1;
                d.wp = pwdata[CTRL_WP_BIT];
                d.top = pwdata[CTRL_TOP_BIT];
                d.uni = pwdata[CTRL_UNI_BIT];
                d.slock = pwdata[CTRL_SLOCK_BIT];
            end else if (paddr == REG_ADDR) begin
                d.addr = pwdata[21:0];
            end else if (paddr == REG_WDATA) begin
                d.wdata = pwdata[15:0];
            end else if (paddr == REG_STATUS) begin
                // write one to clear; later sets in this process win
                if (pwdata[ST_REFUSED_BIT]) d.refused = 1'b0;
                if (pwdata[ST_REDO_BIT]) d.redo = 1'b0;
                if (pwdata[ST_LOST_BIT]) d.lost = 1'b0;
            end
        end
        if (q.cnt != 8'h00) d.cnt = q.cnt - 8'h01;
        // a reset order preempts whatever runs, except a reset pulse already under way
        if (q.go && q.req_op == OP_RESET && q.st != ST_RST) begin
            d.go = 1'b0;
            d.redo_pend = is_pe(q.cur_op) &&
                (q.st == ST_SETUP || q.st == ST_WLOW ||
                 q.st == ST_WHIGH || q.st == ST_BUSY);
            d.pins = '{addr: q.pins.addr, dq_o: 16'h0000, dq_oe: 1'b0,
                       ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, rst_n: 1'b0,
                       wp_n: q.wp};
            d.cnt = RST_CYC;
            d.st = ST_RST;
        end else begin
            case (q.st)
                ST_IDLE: begin
                    if (q.go) begin
                        d.go = 1'b0;
                        if (refuse_f(q.req_op, q.mode, q.addr, q.wp, q.top,
                                     q.uni, q.slock)) begin
                            d.refused = 1'b1;
                        end else begin
                            d.cur_op = q.req_op;
                            d.cur_addr = q.addr;
                            d.cur_data = q.wdata;
                            d.step = 3'd0;
                            if (q.req_op == OP_READ) begin
                                d.pins.addr = q.addr;
                                d.pins.dq_oe = 1'b0;
                                d.pins.ce_n = 1'b0;
                                d.pins.oe_n = 1'b0;
                                d.cnt = READ_CYC + SYNC_CYC;
                                d.st = ST_RD;
                            end else if (q.req_op == OP_EXIT &&
                                         q.mode == MD_READ) begin
                                d.st = ST_IDLE;
                            end else begin
                                d.cnt = SETUP_CYC;
                                d.st = ST_SETUP;
                            end
                        end
                    end
                end
                ST_SETUP: begin
                    // output enable stays high through the whole write
                    d.pins.addr = sq.addr;
                    d.pins.dq_o = sq.data;
                    d.pins.dq_oe = 1'b1;
                    d.pins.oe_n = 1'b1;
                    d.pins.ce_n = 1'b0;
                    d.pins.we_n = 1'b1;
                    if (q.cnt == 8'h00) begin
                        d.pins.we_n = 1'b0;
                        d.cnt = WE_CYC;
                        d.st = ST_WLOW;
                    end
                end
                ST_WLOW: begin
                    if (q.cnt == 8'h00) begin
                        d.pins.we_n = 1'b1;
                        d.cnt = HOLD_CYC;
                        d.st = ST_WHIGH;
                    end
                end
                ST_WHIGH: begin
                    if (q.cnt == 8'h00) begin
                        d.pins.ce_n = 1'b1;
                        d.pins.dq_oe = 1'b0;
                        if (!sq.last) begin
                            d.step = q.step + 3'd1;
                            d.cnt = HOLD_CYC;
                            d.st = ST_RECOV;
                        end else if (is_pe(q.cur_op)) begin
                            d.cnt = ABORT_CYC;
                            d.st = ST_BUSY;
                        end else begin
                            d.cnt = HOLD_CYC;
                            d.st = ST_RECOV;
                            // a stale step would replay the last cycle
                            d.step = 3'd0;
                            case (q.cur_op)
                                OP_QENTER: d.mode = MD_QUERY;
                                OP_IDENT: d.mode = MD_IDENT;
                                OP_SECENT: d.mode = MD_SEC;
                                OP_BENTER: d.mode = MD_BYP;
                                OP_BEXIT: d.mode = MD_READ;
                                OP_EXIT: d.mode = MD_READ;
                                default: d.mode = q.mode;
                            endcase
                        end
                    end
                end
                ST_BUSY: begin
                    // exits are only issued from idle, never while busy
                    if (q.cnt == 8'h00 && stable_rb && q.rb_s[2]) begin
                        d.st = ST_IDLE;
                    end
                end
                ST_RD: begin
                    if (q.cnt == 8'h00 && q.dq_s2 == q.dq_s3) begin
                        d.rdata = q.dq_s3;
                        d.pins.ce_n = 1'b1;
                        d.pins.oe_n = 1'b1;
                        d.cnt = HOLD_CYC;
                        d.st = ST_RECOV;
                    end
                end
                ST_RST: begin
                    if (q.cnt == 8'h00) begin
                        d.pins.rst_n = 1'b1;
                        d.mode = MD_READ;
                        d.step = 3'd0;
                        d.cnt = RHR_CYC;
                        d.st = ST_RECOV;
                    end
                end
                ST_RECOV: begin
                    if (q.cnt == 8'h00) begin
                        if (q.redo_pend) begin
                            // bypass work cannot resume: bypass is gone
                            d.redo_pend = 1'b0;
                            if (q.cur_op == OP_BPROG ||
                                q.cur_op == OP_BSERASE) begin
                                d.lost = 1'b1;
                                d.st = ST_IDLE;
                            end else begin
                                d.redo = 1'b1;
                                d.step = 3'd0;
                                d.cnt = SETUP_CYC;
                                d.st = ST_SETUP;
                            end
                        end else if (q.step != 3'd0) begin
                            d.cnt = SETUP_CYC;
                            d.st = ST_SETUP;
                        end else begin
                            d.st = ST_IDLE;
                        end
                    end
                end
                default: d.st = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.mode <= MD_READ;
            q.pins <= '{addr: 22'h000000, dq_o: 16'h0000, dq_oe: 1'b0,
                        ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, rst_n: 1'b1,
                        wp_n: 1'b0};
            q.rb_s <= 3'b111;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign pins = q.pins;
endmodule : fpm_host

// *** shared/fpm_pkg.sv ***
// Purpose: constants and types of the flash protection/mode host controller
// Assumes: pclk 125 MHz, 4M x16 parallel flash on the far side
// Notes: counts are whole pclk cycles, rounded up
// Operation
// - host reissues a program or erase cut short by hardware reset, except bypass ones (flagged lost) or one cut between its cycles
// - program needs full three-cycle unlock and command sequence
// - erase needs full six-cycle unlock and command sequence
// - host drives upper data byte to valid levels in guarded sequences
package fpm_pkg;
    localparam int CLK_MHZ = 125;
    localparam int SETUP_NS = 10;
    localparam int WE_LOW_NS = 40;
    localparam int HOLD_NS = 20;
    localparam int READ_CYCLE_TIME_NS = 90;
    localparam int RESET_PULSE_MIN_TIME_NS = 500;
    localparam int RESET_TO_READ_DELAY_NS = 50;
    localparam int ABORT_STATUS_NS = 200;
    localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] WE_CYC = 8'((WE_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] READ_CYC =
        8'((READ_CYCLE_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] RST_CYC =
        8'((RESET_PULSE_MIN_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] RHR_CYC =
        8'((RESET_TO_READ_DELAY_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] ABORT_CYC =
        8'((ABORT_STATUS_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] SYNC_CYC = 8'h03;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    // control and status fields
    localparam int CTRL_WP_BIT = 8;
    localparam int CTRL_TOP_BIT = 9;
    localparam int CTRL_UNI_BIT = 10;
    localparam int CTRL_SLOCK_BIT = 11;
    localparam int ST_REFUSED_BIT = 4;
    localparam int ST_REDO_BIT = 5;
    localparam int ST_LOST_BIT = 6;
    // operations
    localparam logic [3:0] OP_RAW = 4'h0;
    localparam logic [3:0] OP_READ = 4'h1;
    localparam logic [3:0] OP_PROG = 4'h2;
    localparam logic [3:0] OP_SERASE = 4'h3;
    localparam logic [3:0] OP_CERASE = 4'h4;
    localparam logic [3:0] OP_BENTER = 4'h5;
    localparam logic [3:0] OP_BPROG = 4'h6;
    localparam logic [3:0] OP_BSERASE = 4'h7;
    localparam logic [3:0] OP_BEXIT = 4'h8;
    localparam logic [3:0] OP_QENTER = 4'h9;
    localparam logic [3:0] OP_IDENT = 4'ha;
    localparam logic [3:0] OP_SECENT = 4'hb;
    localparam logic [3:0] OP_EXIT = 4'hc;
    localparam logic [3:0] OP_RESET = 4'hd;
    // command words, upper byte held low
    localparam logic [21:0] A_555 = 22'h000555;
    localparam logic [21:0] A_2AA = 22'h0002aa;
    localparam logic [21:0] A_55 = 22'h000055;
    localparam logic [15:0] D_AA = 16'h00aa;
    localparam logic [15:0] D_55 = 16'h0055;
    localparam logic [15:0] D_PROG = 16'h00a0;
    localparam logic [15:0] D_ERASE = 16'h0080;
    localparam logic [15:0] D_SECT = 16'h0050;
    localparam logic [15:0] D_CHIP = 16'h0010;
    localparam logic [15:0] D_BENTER = 16'h0020;
    localparam logic [15:0] D_BEXIT1 = 16'h0090;
    localparam logic [15:0] D_BEXIT2 = 16'h0000;
    localparam logic [15:0] D_QUERY = 16'h0098;
    localparam logic [15:0] D_IDENT = 16'h0090;
    localparam logic [15:0] D_SECENT = 16'h0088;
    localparam logic [15:0] D_EXIT = 16'h00f0;
    // boot areas and secure ID end
    localparam logic [21:0] BOOT_UNI_BOT_END = 22'h007fff;
    localparam logic [21:0] BOOT_UNI_TOP_BEG = 22'h3f8000;
    localparam logic [21:0] BOOT_NU_BOT_END = 22'h001fff;
    localparam logic [21:0] BOOT_NU_TOP_BEG = 22'h3fe000;
    localparam logic [21:0] SEC_UID_END = 22'h000007;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_WLOW = 3'b011,
        ST_WHIGH = 3'b010, ST_BUSY = 3'b110, ST_RD = 3'b111,
        ST_RST = 3'b101, ST_RECOV = 3'b100
    } fpm_state_e;

    typedef enum logic [2:0] {
        MD_READ = 3'h0, MD_QUERY = 3'h1, MD_IDENT = 3'h2,
        MD_SEC = 3'h3, MD_BYP = 3'h4
    } fpm_mode_e;

    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] dq_o;
        logic dq_oe;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic rst_n;
        logic wp_n;
    } fpm_pins_s;

    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] data;
        logic last;
    } fpm_seq_s;
endpackage : fpm_pkg

// *** test/fpm_host_chk.sv ***
// Purpose: port checks on the flash protection host controller
// Assumes: one clock domain, async active-low reset
// Notes: strobe checks watch the registered flash pins
module fpm_host_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire fpm_pkg::fpm_pins_s pins
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a strobe this long can never look like a glitch to the flash
    sequence we_pulse;
        (!pins.we_n)[*6] ##1 pins.we_n;
    endsequence
    chk_we_width: assert property ($fell(pins.we_n) |-> we_pulse)
        else $error("write strobe width off");
    chk_we_inhibit: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n)
        else $error("write strobe outside select");
    chk_we_drive: assert property (!pins.we_n |-> pins.dq_oe)
        else $error("data not driven in write");
    chk_addr_hold: assert property (!pins.ce_n && $past(!pins.ce_n)
        |-> $stable(pins.addr))
        else $error("address moved in cycle");
    chk_rst_width: assert property ($fell(pins.rst_n) |-> (!pins.rst_n)[*8])
        else $error("reset pulse short");
    chk_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule : fpm_host_chk

bind fpm_host fpm_host_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .pins(pins));

// *** test/fpm_flash_model.sv ***
// Purpose: behavioural flash on the far side of the host controller
// Assumes: bottom uniform boot area, program, bypass and identify only
// Notes: maker code is arbitrary
module fpm_flash_model #(parameter logic [15:0] MAKER = 16'h00c5) (
    input wire logic [21:0] addr,
    input wire logic [15:0] dq,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic rst_n,
    input wire logic wp_n,
    output logic [15:0] dq_o,
    output logic ry_by_n
);
    logic [15:0] mem [int];
    logic [15:0] last = 16'h0;
    logic ident = 1'b0;
    logic byp = 1'b0;
    int step = 0;
    initial ry_by_n = 1'b1;
    always @(negedge rst_n) begin
        step = 0;
        ident = 1'b0;
        byp = 1'b0;
    end
    // write latched at strobe release, not while output enable low
    always @(posedge we_n) begin
        if (!ce_n && oe_n && rst_n) begin
            case (step)
                0: begin
                    if (byp && dq[7:0] == 8'h90) byp = 1'b0;
                    step = (byp && dq[7:0] == 8'ha0) ? 3 :
                        (addr == 22'h555 && dq[7:0] == 8'haa) ? 1 : 0;
                end
                1: step = (addr == 22'h2aa && dq[7:0] == 8'h55) ? 2 : 0;
                2: begin
                    ident = ident | (dq[7:0] == 8'h90);
                    byp = byp | (dq[7:0] == 8'h20);
                    step = (dq[7:0] == 8'ha0) ? 3 : 0;
                end
                default: begin
                    if (wp_n || addr > 22'h007fff) begin
                        mem[addr] = dq;
                    end
                    ry_by_n <= 1'b0;
                    ry_by_n <= #400 1'b1;
                    step = 0;
                end
            endcase
            if (step == 0 && dq[7:0] == 8'hf0) begin
                ident = 1'b0;
            end
        end
    end
    always @(posedge oe_n) last <= dq_o;
    // released bus shows a changing pattern, never the last word
    always @* begin
        if (!ce_n && !oe_n) begin
            dq_o = ident ? (addr == 22'h0 ? MAKER : 16'h0) :
                (mem.exists(addr) ? mem[addr] : 16'hffff);
        end else begin
            dq_o = ~last;
        end
    end
endmodule : fpm_flash_model

// *** test/fpm_host_bench.sv ***
// Purpose: self-checking bench of the flash protection host controller
// Assumes: flash model with bottom uniform boot area
// Notes: expectations are the bench's written words and constants
module fpm_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import fpm_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ry;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, ctrl, q;
    logic pready, pslverr, err;
    logic [15:0] fl_q;
    wire [15:0] bus;
    fpm_pins_s pins;
    int n_mismatch = 0, check_count = 0, cyc = 0, i;
    logic [15:0] exp_mem [int];
    logic [21:0] a;
    logic [15:0] d;
    always #4 pclk = ~pclk;
    assign bus = pins.dq_oe ? pins.dq_o : fl_q;
    fpm_host dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .dq_i(bus), .ry_by_n_i(ry));
    fpm_flash_model flash (.addr(pins.addr), .dq(bus), .ce_n(pins.ce_n),
        .we_n(pins.we_n), .oe_n(pins.oe_n), .rst_n(pins.rst_n),
        .wp_n(pins.wp_n), .dq_o(fl_q), .ry_by_n(ry));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        if (n_mismatch == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic op(input logic [3:0] c, input logic [21:0] ad,
                      input logic [15:0] wd);
        apb(1'b1, REG_ADDR, 32'(ad));
        apb(1'b1, REG_WDATA, 32'(wd));
        apb(1'b1, REG_CTRL, ctrl | 32'(c));
        // busy may last through the flash's own program time
        for (int k = 0; k < 300; k++) begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (q[3] === 1'b0) break;
        end
    endtask : op
    task automatic read_back(input logic [21:0] ad, input logic [15:0] e);
        op(OP_READ, ad, 16'h0);
        apb(1'b0, REG_RDATA, 32'h0);
        check(q, 32'(e));
    endtask : read_back
    // refused bit, busy and mode after an op; sticky bits cleared after
    task automatic op_st(input logic [3:0] c, input logic [21:0] ad,
                         input logic [31:0] e);
        op(c, ad, 16'h0);
        check(q & 32'h1f, e);
        apb(1'b1, REG_STATUS, 32'h70);
    endtask : op_st
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'hcf6074bd));
        ctrl = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, REG_CTRL, 32'h0);
        check(q, 32'h0);
        check(32'(err), 32'h0);
        check({31'h0, pins.wp_n}, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check(q, 32'h0);
        check(32'(err), 32'h1);
        ctrl = 32'h500; // writable, bottom uniform boot
        for (i = 0; i < 5; i++) begin
            a = (i == 0) ? 22'h007fff : 22'($urandom_range(32'h3fffff, 32'h8000));
            d = 16'($urandom);
            op(OP_PROG, a, d);
            exp_mem[a] = d;
            read_back(a, d);
        end
        ctrl = 32'h400;
        op(OP_PROG, 22'h000100, 16'h1234);
        apb(1'b0, REG_STATUS, 32'h0);
        check(32'(q[4]), 32'h1);
        apb(1'b1, REG_STATUS, 32'h10);
        read_back(22'h000100, 16'hffff);
        op(OP_RAW, A_555, D_AA);
        op(OP_RAW, 22'h000123, 16'h0000);
        op(OP_RAW, A_555, D_PROG);
        op(OP_RAW, 22'h200000, 16'h00ab);
        read_back(22'h200000, 16'hffff);
        op(OP_IDENT, 22'h0, 16'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        check(32'(q[2:0]), 32'h2);
        read_back(22'h0, 16'h00c5);
        op(OP_EXIT, 22'h0, 16'h0);
        read_back(a, d);
        op(OP_IDENT, 22'h0, 16'h0);
        op(OP_RESET, 22'h0, 16'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        check(32'(q[2:0]), 32'h0);
        read_back(a, d);
        ctrl = 32'h0;
        op_st(OP_PROG, 22'h001fff, 32'h10);
        ctrl = 32'h200;
        op_st(OP_SERASE, 22'h3fe000, 32'h10);
        op_st(OP_PROG, 22'h3fdfff, 32'h0);
        ctrl = 32'h500;
        op_st(OP_QENTER, 22'h0, 32'h1);
        op_st(OP_EXIT, 22'h0, 32'h0);
        op_st(OP_BENTER, 22'h0, 32'h4);
        d = 16'($urandom);
        op(OP_BPROG, 22'h00b0b0, d);
        read_back(22'h00b0b0, d);
        op_st(OP_PROG, 22'h00a5a5, 32'h14);
        op_st(OP_BEXIT, 22'h0, 32'h0);
        // program of a zero word cut by a reset order must be reissued
        apb(1'b1, REG_ADDR, 32'h0000a5a5);
        apb(1'b1, REG_CTRL, ctrl | 32'(OP_PROG));
        op(OP_RESET, 22'h00a5a5, 16'h0);
        check(32'(q[5]), 32'h1);
        read_back(22'h00a5a5, 16'h0000);
        op_st(OP_SECENT, 22'h0, 32'h3);
        op_st(OP_SERASE, 22'h000100, 32'h13);
        op_st(OP_PROG, 22'h000007, 32'h13);
        ctrl = 32'hd00;
        op_st(OP_PROG, 22'h000100, 32'h13);
        op_st(OP_EXIT, 22'h0, 32'h0);
        tally_and_finish();
    end
endmodule : fpm_host_bench
